// file: rtl/ftms_defines.vh
// constants of the fuser thermal and motor supervisor
`ifndef FTMS_DEFINES_VH
`define FTMS_DEFINES_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define FTMS_OFS_CTRL      8'h00
`define FTMS_OFS_REF_HALF  8'h04
`define FTMS_OFS_PRESS_REF 8'h08
`define FTMS_OFS_STATUS    8'h0C
`define FTMS_OFS_FAULT_CNT 8'h10
`define FTMS_OFS_INT_STAT  8'h14
`define FTMS_OFS_INT_MASK  8'h18
`define FTMS_OFS_PROV      8'h1C

// ************************************************************
// control fields and reset values
// ************************************************************
`define FTMS_CTRL_RUN      0
`define FTMS_CTRL_CHECK    1
`define FTMS_CTRL_MODE_LO  2
`define FTMS_CTRL_MODE_HI  3
`define FTMS_CTRL_SLOW     4
`define FTMS_CTRL_RST      5'h00
`define FTMS_REF_HALF_RST  16'h0005
`define FTMS_PRESS_REF_RST 10'h064
`define FTMS_CHECK_DIV     16'h00FA

// operating modes
`define FTMS_MODE_READY    2'h0
`define FTMS_MODE_PRINT    2'h1
`define FTMS_MODE_SAVE     2'h2
`define FTMS_MODE_JAM      2'h3

// interrupt bits
`define FTMS_INT_PROV      0
`define FTMS_INT_CONFIRM   1
`define FTMS_INT_LOCK_ON   2
`define FTMS_INT_LOCK_OFF  3

// ************************************************************
// temperature thresholds, signed degrees C, 10 bits
// ************************************************************
`define FTMS_T_CENTER_HOT  10'h0F0
`define FTMS_T_REAR_HOT    10'h0FA
`define FTMS_T_FRONT_HOT   10'h10E
`define FTMS_T_PRESS_HOT   10'h0FA
`define FTMS_T_ROLL_COLD   10'h028
`define FTMS_T_PRESS_COLD  10'h000

// ************************************************************
// error codes and fault counter values
// ************************************************************
`define FTMS_CODE_HOT      12'h449
`define FTMS_CODE_COLD     12'h447
`define FTMS_CODE_PCOLD    12'h467
`define FTMS_CODE_PHOT     12'h468
`define FTMS_CNT_RDY_HOT   5'h17
`define FTMS_CNT_RDY_COLD  5'h07
`define FTMS_CNT_PRT_HOT   5'h19
`define FTMS_CNT_PRT_COLD  5'h18
`define FTMS_CNT_SAV_HOT   5'h1B
`define FTMS_CNT_SAV_PHOT  5'h1A
`define FTMS_CNT_JAM_HOT   5'h1D
`define FTMS_CNT_JAM_PHOT  5'h1C

`endif

// file: rtl/ftms_lock.v
// period comparison of the speed feedback pulse against the reference
`timescale 1ns/100ps
module ftms_lock #(
  parameter W = 17
) (
  input wire hclk,
  input wire hresetn,
  input wire enable,
  input wire fb_rise,
  input wire [W-1:0] ref_period,
  output reg locked_r
);

  reg [W-1:0] cnt_r;
  reg [W-1:0] diff;
  wire [W+3:0] diff_x16;
  wire stalled;

  // absolute deviation of the measured period from the reference
  always @* begin
    if (cnt_r >= ref_period) begin
      diff = cnt_r - ref_period;
    end else begin
      diff = ref_period - cnt_r;
    end
  end

  assign diff_x16 = {diff, 4'h0};
  // no edge for twice the reference period means the motor stands
  assign stalled = (cnt_r > {ref_period[W-2:0], 1'b0});

  // lock within one sixteenth, i.e. 6.25 percent of the reference
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= {W{1'b0}};
      locked_r <= 1'b0;
    end else if (!enable) begin
      cnt_r <= {W{1'b0}};
      locked_r <= 1'b0;
    end else if (fb_rise) begin
      cnt_r <= {{(W-1){1'b0}}, 1'b1};
      locked_r <= (diff_x16 <= {4'h0, ref_period}); // RULE14
    end else begin
      if (!stalled) begin
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      end
      if (stalled) begin
        locked_r <= 1'b0;
      end
    end
  end

endmodule // ftms_lock

// file: rtl/ftms_top.v
// fuser thermal supervisor and fuser motor command, AHB-Lite slave
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "ftms_defines.vh"
// How it works
// RULE1: over-temperature group is checked before under-temperature group.
// RULE2: first detection is provisional; a repeat on next check confirms.
// RULE3: ready mode hot roller raises C449, counter 23, checked always; here checked only while the CTRL check bit is set.
// RULE4: ready mode roller 40C or below C447/7; pressure 0C gives C467.
// RULE5: printing hot roller raises C449, counter 25.
// RULE6: printing cold roller raises C447/24; cold pressure roller C467.
// RULE7: energy saving hot roller C449/27; pressure 250C C468/26.
// RULE8: paper jam hot roller C449/29; pressure 250C C468/28.
// RULE9: motor run command low rotates motor, high stops it.
// RULE10: speed select low means slow rotation, high means fast.
// RULE11: ready with pressure roller below reference selects low speed.
// RULE12: reference clock for motor speed is supplied continuously.
// RULE13: driver compares feedback with reference and corrects timing.
// RULE14: lock when feedback period is within 6.25 percent of reference.
// RULE15: driver lights its lamp while the feedback is locked.
// RULE16: driver senses rotor position and switches phase excitation.
// RULE17: fault counter must be written to zero before normal start.
// RULE18: confirmed error latches code and counter and stops the motor.
module ftms_top #(
  parameter TW = 10,
  parameter [15:0] CHECK_DIV = `FTMS_CHECK_DIV
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire signed [TW-1:0] temp_center,
  input wire signed [TW-1:0] temp_rear,
  input wire signed [TW-1:0] temp_front,
  input wire signed [TW-1:0] temp_press,
  input wire speed_feedback_pulse,
  output reg motor_run_n,
  output reg motor_low_speed_n,
  output reg motor_speed_ref_clock,
  output reg irq
);

  // ************************************************************
  // registers and state
  // ************************************************************
  reg [4:0] ctrl_r;
  reg [15:0] ref_half_r;
  reg signed [TW-1:0] press_ref_r;
  reg [3:0] int_stat_r;
  reg [3:0] int_stat_nxt;
  reg [3:0] int_mask_r;
  reg [11:0] err_code_r;
  reg [4:0] err_cnt_r;
  reg err_conf_r;
  reg prov_r;
  reg [11:0] prov_code_r;
  reg [4:0] prov_cnt_r;
  reg pend_r;
  reg pend_write_r;
  reg [7:0] pend_addr_r;
  reg [15:0] tick_cnt_r;
  reg tick_r;
  reg [15:0] ref_cnt_r;
  reg fb_meta_r;
  reg fb_sync_r;
  reg fb_prev_r;
  reg lock_prev_r;
  wire locked;
  wire [1:0] mode;
  wire run_req;
  wire check_en;
  wire addr_phase;
  wire fault_wr;
  wire stat_rd;
  wire fb_rise;
  wire [16:0] ref_period;
  reg [31:0] rd_mux;

  assign mode = ctrl_r[`FTMS_CTRL_MODE_HI:`FTMS_CTRL_MODE_LO];
  assign run_req = ctrl_r[`FTMS_CTRL_RUN];
  assign check_en = ctrl_r[`FTMS_CTRL_CHECK];

  // ************************************************************
  // AHB-Lite slave: one wait state per transfer
  // ************************************************************
  // the wait state lets hrdata come from a flop and keeps the
  // read-to-clear of the interrupt status on a single edge
  assign addr_phase = hsel & htrans[1] & hready;
  assign fault_wr = pend_r & pend_write_r &
                    (pend_addr_r == `FTMS_OFS_FAULT_CNT);
  assign stat_rd = pend_r & ~pend_write_r &
                   (pend_addr_r == `FTMS_OFS_INT_STAT);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      pend_write_r <= 1'b0;
      pend_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (pend_r) begin
      pend_r <= 1'b0;
      hreadyout <= 1'b1;
    end else if (addr_phase) begin
      pend_r <= 1'b1;
      pend_write_r <= hwrite;
      pend_addr_r <= {haddr[7:2], 2'b00};
      hreadyout <= 1'b0;
    end
  end

  // read data mux; unmapped offsets read as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    case (pend_addr_r)
      `FTMS_OFS_CTRL: rd_mux[4:0] = ctrl_r;
      `FTMS_OFS_REF_HALF: rd_mux[15:0] = ref_half_r;
      `FTMS_OFS_PRESS_REF: rd_mux[TW-1:0] = press_ref_r;
      `FTMS_OFS_STATUS: begin
        rd_mux[11:0] = err_code_r;
        rd_mux[12] = err_conf_r;
        rd_mux[13] = prov_r;
        rd_mux[14] = locked;
        rd_mux[15] = ~motor_low_speed_n;
        rd_mux[16] = ~motor_run_n;
      end
      `FTMS_OFS_FAULT_CNT: rd_mux[4:0] = err_cnt_r;
      `FTMS_OFS_INT_STAT: rd_mux[3:0] = int_stat_r;
      `FTMS_OFS_INT_MASK: rd_mux[3:0] = int_mask_r;
      `FTMS_OFS_PROV: begin
        rd_mux[11:0] = prov_code_r;
        rd_mux[20:16] = prov_cnt_r;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // register writes land in the data phase cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      ctrl_r <= `FTMS_CTRL_RST;
      ref_half_r <= `FTMS_REF_HALF_RST;
      press_ref_r <= `FTMS_PRESS_REF_RST;
      int_mask_r <= 4'h0;
    end else if (pend_r) begin
      if (!pend_write_r) begin
        hrdata <= rd_mux;
      end else begin
        case (pend_addr_r)
          `FTMS_OFS_CTRL: ctrl_r <= hwdata[4:0];
          `FTMS_OFS_REF_HALF: ref_half_r <= hwdata[15:0];
          `FTMS_OFS_PRESS_REF: press_ref_r <= hwdata[TW-1:0];
          `FTMS_OFS_INT_MASK: int_mask_r <= hwdata[3:0];
          default: ctrl_r <= ctrl_r;
        endcase
      end
    end
  end

  // ************************************************************
  // temperature checking
  // ************************************************************
  wire roll_hot;
  wire roll_cold;
  wire press_hot;
  wire press_cold;
  reg cand_vld;
  reg [11:0] cand_code;
  reg [4:0] cand_cnt;

  assign roll_hot = (temp_center >= $signed(`FTMS_T_CENTER_HOT)) |
                    (temp_rear >= $signed(`FTMS_T_REAR_HOT)) |
                    (temp_front >= $signed(`FTMS_T_FRONT_HOT));
  assign roll_cold = (temp_center <= $signed(`FTMS_T_ROLL_COLD)) |
                     (temp_rear <= $signed(`FTMS_T_ROLL_COLD)) |
                     (temp_front <= $signed(`FTMS_T_ROLL_COLD));
  assign press_hot = (temp_press >= $signed(`FTMS_T_PRESS_HOT));
  assign press_cold = (temp_press <= $signed(`FTMS_T_PRESS_COLD));

  // per mode, the hot group always wins over the cold group
  always @* begin
    cand_vld = 1'b0;
    cand_code = 12'h000;
    cand_cnt = 5'h00;
    case (mode)
      `FTMS_MODE_READY: begin
        cand_vld = roll_hot | roll_cold | press_cold;
        if (roll_hot) begin // RULE1
          cand_code = `FTMS_CODE_HOT; // RULE3
          cand_cnt = `FTMS_CNT_RDY_HOT;
        end else if (roll_cold) begin
          cand_code = `FTMS_CODE_COLD; // RULE4
          cand_cnt = `FTMS_CNT_RDY_COLD;
        end else if (press_cold) begin
          cand_code = `FTMS_CODE_PCOLD; // RULE4
          cand_cnt = `FTMS_CNT_RDY_COLD;
        end
      end
      `FTMS_MODE_PRINT: begin
        cand_vld = roll_hot | roll_cold | press_cold;
        if (roll_hot) begin // RULE1
          cand_code = `FTMS_CODE_HOT; // RULE5
          cand_cnt = `FTMS_CNT_PRT_HOT;
        end else if (roll_cold) begin
          cand_code = `FTMS_CODE_COLD; // RULE6
          cand_cnt = `FTMS_CNT_PRT_COLD;
        end else if (press_cold) begin
          cand_code = `FTMS_CODE_PCOLD; // RULE6
          cand_cnt = `FTMS_CNT_PRT_COLD;
        end
      end
      `FTMS_MODE_SAVE: begin
        cand_vld = roll_hot | press_hot;
        if (roll_hot) begin
          cand_code = `FTMS_CODE_HOT; // RULE7
          cand_cnt = `FTMS_CNT_SAV_HOT;
        end else if (press_hot) begin
          cand_code = `FTMS_CODE_PHOT; // RULE7
          cand_cnt = `FTMS_CNT_SAV_PHOT;
        end
      end
      default: begin
        cand_vld = roll_hot | press_hot;
        if (roll_hot) begin
          cand_code = `FTMS_CODE_HOT; // RULE8
          cand_cnt = `FTMS_CNT_JAM_HOT;
        end else if (press_hot) begin
          cand_code = `FTMS_CODE_PHOT; // RULE8
          cand_cnt = `FTMS_CNT_JAM_PHOT;
        end
      end
    endcase
  end

  // check cadence; runs whenever checking is enabled
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r >= CHECK_DIV - 16'h0001) begin
      tick_cnt_r <= 16'h0000;
      tick_r <= check_en;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // a single hit is only provisional; the same code on the next
  // check confirms it and latches code and counter until cleared
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prov_r <= 1'b0;
      prov_code_r <= 12'h000;
      prov_cnt_r <= 5'h00;
      err_conf_r <= 1'b0;
      err_code_r <= 12'h000;
      err_cnt_r <= 5'h00;
    end else begin
      if (tick_r && !err_conf_r) begin
        if (cand_vld && prov_r && cand_code == prov_code_r) begin
          err_conf_r <= 1'b1; // RULE18
          err_code_r <= cand_code;
          err_cnt_r <= cand_cnt;
          prov_r <= 1'b0; // RULE2
        end else begin
          prov_r <= cand_vld; // RULE2
          prov_code_r <= cand_code;
          prov_cnt_r <= cand_cnt;
        end
      end else if (fault_wr && hwdata[4:0] == 5'h00) begin
        err_conf_r <= 1'b0; // RULE17
        err_cnt_r <= 5'h00;
        err_code_r <= 12'h000;
      end
    end
  end

  // ************************************************************
  // motor commands, reference clock, feedback lock
  // ************************************************************
  // the reference clock free-runs even while the motor is stopped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt_r <= 16'h0000;
      motor_speed_ref_clock <= 1'b0;
    end else if (ref_cnt_r >= ref_half_r) begin
      ref_cnt_r <= 16'h0000;
      motor_speed_ref_clock <= ~motor_speed_ref_clock; // RULE12
    end else begin
      ref_cnt_r <= ref_cnt_r + 16'h0001;
    end
  end

  // motor stays stopped while a confirmed fault is latched
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motor_run_n <= 1'b1;
      motor_low_speed_n <= 1'b1;
    end else begin
      motor_run_n <= ~(run_req & ~err_conf_r); // RULE9 RULE18
      motor_low_speed_n <= ~(ctrl_r[`FTMS_CTRL_SLOW] | // RULE10
        (mode == `FTMS_MODE_READY && temp_press < press_ref_r)); // RULE11
    end
  end

  // feedback pin is asynchronous: two flops before anything reads it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fb_meta_r <= 1'b0;
      fb_sync_r <= 1'b0;
      fb_prev_r <= 1'b0;
    end else begin
      fb_meta_r <= speed_feedback_pulse;
      fb_sync_r <= fb_meta_r;
      fb_prev_r <= fb_sync_r;
    end
  end

  assign fb_rise = fb_sync_r & ~fb_prev_r;
  assign ref_period = {ref_half_r, 1'b0} + 17'h0_0002;

  ftms_lock #(
    .W(17)
  ) u_lock (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(~motor_run_n),
    .fb_rise(fb_rise),
    .ref_period(ref_period),
    .locked_r(locked)
  );

  // ************************************************************
  // interrupt status: sticky, cleared by reading, set wins
  // ************************************************************
  always @* begin
    int_stat_nxt = int_stat_r;
    if (stat_rd) begin
      int_stat_nxt = 4'h0;
    end
    if (tick_r && !err_conf_r && cand_vld &&
        !(prov_r && cand_code == prov_code_r)) begin
      int_stat_nxt[`FTMS_INT_PROV] = 1'b1;
    end
    if (tick_r && !err_conf_r && cand_vld && prov_r &&
        cand_code == prov_code_r) begin
      int_stat_nxt[`FTMS_INT_CONFIRM] = 1'b1;
    end
    if (locked && !lock_prev_r) begin
      int_stat_nxt[`FTMS_INT_LOCK_ON] = 1'b1;
    end
    if (!locked && lock_prev_r) begin
      int_stat_nxt[`FTMS_INT_LOCK_OFF] = 1'b1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_r <= 4'h0;
      lock_prev_r <= 1'b0;
      irq <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      lock_prev_r <= locked;
      irq <= |(int_stat_nxt & int_mask_r);
    end
  end

endmodule // ftms_top

// file: verification/ftms_top_props.sv
// assertions on the supervisor's bus and motor pins
`timescale 1ns/100ps
module ftms_top_props #(
  parameter TW = 10,
  parameter [15:0] CHECK_DIV = 16'h00FA
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire motor_run_n,
  input wire motor_low_speed_n,
  input wire motor_speed_ref_clock,
  input wire irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // transfer decode as the slave sees it
  wire tk = hsel && htrans[1] && hready;
  wire rdt = tk && !hwrite;
  wire wr0 = tk && hwrite && haddr[7:2] == 6'h00;
  wire wrm = tk && hwrite && haddr[7:2] == 6'h06;
  wire wrx = tk && hwrite && (haddr[7:2] == 6'h00 || haddr[7:2] == 6'h04);
  wire wrh = tk && hwrite && haddr[7:2] == 6'h01;
  wire tgl;
  reg ck_r;
  reg [16:0] cnt_r;
  reg [16:0] last_r;
  reg [1:0] ok_r;
  assign tgl = motor_speed_ref_clock ^ ck_r;
  // half periods of the reference; a divider write spoils two halves
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_r <= 1'b0;
      cnt_r <= 17'h0_0000;
      last_r <= 17'h0_0000;
      ok_r <= 2'h0;
    end else begin
      ck_r <= motor_speed_ref_clock;
      cnt_r <= tgl ? 17'h0_0001 : cnt_r + 17'h0_0001;
      if (tgl) last_r <= cnt_r;
      if (wrh) ok_r <= 2'h0;
      else if (tgl && ok_r != 2'h2) ok_r <= ok_r + 2'h1;
    end
  end
  AST_REF_EVEN: assert property (
    tgl && ok_r == 2'h2 |-> cnt_r == last_r)
    else $error("reference clock half periods differ");
  AST_RUN_STOP: assert property (
    wr0 ##1 !hwdata[0] |-> ##2 motor_run_n)
    else $error("motor not stopped after run cleared");
  AST_FORCE_SLOW: assert property (
    wr0 ##1 hwdata[4] |-> ##2 !motor_low_speed_n)
    else $error("slow select not driven low");
  AST_START_WRITE: assert property (
    $fell(motor_run_n) |-> $past(wrx, 3))
    else $error("motor started without a control or counter write");
  AST_BUS_WAIT: assert property (tk |=> !hreadyout ##1 hreadyout)
    else $error("slave wait state not exactly one cycle");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  AST_UNMAPPED: assert property (rdt && haddr[7:5] != 3'h0 |-> ##2 hrdata == 0)
    else $error("unmapped read returned data");
  AST_READ_HOLD: assert property ($changed(hrdata) |-> $past(rdt, 2))
    else $error("read data changed without a read");
  AST_MASK_QUIET: assert property (wrm ##1 hwdata[3:0] == 4'h0 |-> ##2 !irq)
    else $error("interrupt high with all sources masked");
endmodule // ftms_top_props
bind ftms_top ftms_top_props #(.TW(TW), .CHECK_DIV(CHECK_DIV)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .motor_run_n(motor_run_n), .motor_low_speed_n(motor_low_speed_n),
  .motor_speed_ref_clock(motor_speed_ref_clock), .irq(irq));

// file: verification/ftms_motor_model.sv
// fuser motor driver board model that follows the reference clock
`timescale 1ns/100ps
module ftms_motor_model (
  input wire motor_run_n,
  input wire motor_speed_ref_clock,
  input wire [7:0] skew_pct,
  output logic speed_feedback_pulse,
  output logic lamp
);
  realtime t_r = 0;
  realtime per_r = 0;
  // reference period taken from its rising edges
  always @(posedge motor_speed_ref_clock) begin
    per_r = $realtime - t_r;
    t_r = $realtime;
  end
  // rotor sensing and commutation folded into one delay; skew_pct
  // stands for a driver that cannot pull the speed onto the reference
  always begin
    if (motor_run_n || per_r == 0) begin
      speed_feedback_pulse = 1'b0;
      @(negedge motor_run_n or posedge motor_speed_ref_clock);
    end else begin
      #(per_r * skew_pct / 200.0);
      speed_feedback_pulse = ~speed_feedback_pulse;
    end
  end
  // lamp lit inside plus or minus 6.25 percent
  assign lamp = !motor_run_n &&
    skew_pct > 8'h5D && skew_pct < 8'h6B;
endmodule // ftms_motor_model

// file: verification/ftms_top_tb_top.sv
// self-checking bench of the fuser supervisor
`timescale 1ns/100ps
`include "ftms_defines.vh"
`define CK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); \
  end \
end
module ftms_top_tb_top;
  localparam int N = 1000;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] rs = 32'h0000_4AE5;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [9:0] tc = 10'h064;
  logic [9:0] tr = 10'h064;
  logic [9:0] tf = 10'h064;
  logic [9:0] tp = 10'h064;
  logic [7:0] skew = 8'h64;
  logic rd_ph = 1'b0;
  logic [63:0] q[$];
  logic [63:0] e;
  wire hreadyout, hresp, run_n, slow_n, refck, irq, fb, lamp;
  wire [31:0] hrdata;
  // ********
  // design and far side
  // ********
  ftms_top #(.CHECK_DIV(16'h0028)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .temp_center(tc), .temp_rear(tr),
    .temp_front(tf), .temp_press(tp), .speed_feedback_pulse(fb),
    .motor_run_n(run_n), .motor_low_speed_n(slow_n),
    .motor_speed_ref_clock(refck), .irq(irq));
  ftms_motor_model motor (.motor_run_n(run_n),
    .motor_speed_ref_clock(refck), .skew_pct(skew),
    .speed_feedback_pulse(fb), .lamp(lamp));
  // clock and hang guard
  initial forever #2 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      give_verdict();
    end
  end
  // read data judged at the edge that ends its data phase
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      e = q.pop_front();
      `CK(hrdata & e[31:0], e[63:32])
    end
    if (hreadyout === 1'b1) rd_ph <= hsel && htrans[1] && !hwrite;
  end
  task automatic give_verdict();
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // nominal readings are random but clear of every threshold
  function automatic logic [9:0] tv(input int v);
    return (v == N) ? 10'(50 + rnd() % 150) : 10'(v);
  endfunction
  // one single transfer, held until the slave is ready
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v,
      input logic [31:0] k);
    q.push_back({v & k, k});
    xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wait_irq();
    int n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    `CK(irq, 1'b1)
  endtask
  task automatic ref_per(input int exp_n);
    realtime t0;
    @(posedge refck);
    t0 = $realtime;
    @(posedge refck);
    `CK(int'(($realtime - t0) / 4.0), exp_n)
  endtask
  // ********
  // main sequence
  // ********
  initial begin
    int row[12][7] = '{
      '{0, 240, N, N, N, 'h449, 23}, '{0, N, 250, 40, N, 'h449, 23},
      '{0, N, N, 40, N, 'h447, 7}, '{0, N, N, N, 0, 'h467, 7},
      '{1, N, N, 270, N, 'h449, 25}, '{1, 40, N, N, N, 'h447, 24},
      '{1, N, N, N, -5, 'h467, 24}, '{2, N, N, N, 250, 'h468, 26},
      '{2, N, 250, N, N, 'h449, 27}, '{2, 40, N, N, 0, 0, 0},
      '{3, N, N, 270, N, 'h449, 29}, '{3, 239, 249, 269, 249, 0, 0}};
    logic [7:0] sl[4][3] = '{'{1, 99, 0}, '{1, 100, 1}, '{5, 50, 1},
      '{21, 150, 0}};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`FTMS_OFS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`FTMS_OFS_REF_HALF, 32'h0000_0005, 32'hFFFF_FFFF);
    rd(`FTMS_OFS_PRESS_REF, 32'h0000_0064, 32'hFFFF_FFFF);
    rd(`FTMS_OFS_INT_MASK, 32'h0000_0000, 32'hFFFF_FFFF);
    xfer(1'b1, 8'h20, rnd());
    rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    ref_per(12);
    xfer(1'b1, `FTMS_OFS_INT_MASK, 32'h0000_0001);
    foreach (row[i]) begin
      {tc, tr, tf, tp} <= {tv(N), tv(N), tv(N), tv(N)};
      xfer(1'b1, `FTMS_OFS_FAULT_CNT, 32'h0000_0000);
      // an earlier faulty row leaves both its provisional and confirm bits
      rd(`FTMS_OFS_INT_STAT, (i > 0 && row[i-1][5] != 0) ?
        32'h0000_0003 : 32'h0000_0000, 32'h0000_0003);
      xfer(1'b1, `FTMS_OFS_CTRL, 32'(row[i][0] * 4 + 3));
      repeat (2) @(posedge hclk);
      `CK(run_n, 1'b0)
      {tc, tr, tf, tp} <= {tv(row[i][1]), tv(row[i][2]), tv(row[i][3]),
        tv(row[i][4])};
      if (row[i][5] != 0) begin
        wait_irq();
        rd(`FTMS_OFS_PROV, {11'h0, 5'(row[i][6]), 4'h0, 12'(row[i][5])},
          32'h001F_0FFF);
        repeat (100) @(posedge hclk);
        rd(`FTMS_OFS_STATUS, {19'h0_0000, 1'b1, 12'(row[i][5])},
          32'h0001_1FFF);
        rd(`FTMS_OFS_FAULT_CNT, 32'(row[i][6]), 32'h0000_001F);
        xfer(1'b1, `FTMS_OFS_FAULT_CNT, 32'h0000_0011);
        rd(`FTMS_OFS_FAULT_CNT, 32'(row[i][6]), 32'h0000_001F);
        `CK(run_n, 1'b1)
      end else begin
        repeat (100) @(posedge hclk);
        `CK(irq, 1'b0)
        rd(`FTMS_OFS_STATUS, 32'h0001_0000, 32'h0001_1FFF);
      end
    end
    {tc, tr, tf, tp} <= {tv(N), tv(N), tv(N), tv(N)};
    xfer(1'b1, `FTMS_OFS_FAULT_CNT, 32'h0000_0000);
    foreach (sl[i]) begin
      tp <= 10'(sl[i][1]);
      xfer(1'b1, `FTMS_OFS_CTRL, 32'(sl[i][0]));
      repeat (3) @(posedge hclk);
      `CK(slow_n, sl[i][2][0])
      rd(`FTMS_OFS_STATUS, {16'h0, ~sl[i][2][0], 15'h0}, 32'h0000_8000);
    end
    xfer(1'b1, `FTMS_OFS_CTRL, 32'h0000_0000);
    xfer(1'b1, `FTMS_OFS_REF_HALF, 32'h0000_0063);
    ref_per(200);
    // stopping a locked motor must leave the lock-lost bit behind
    rd(`FTMS_OFS_INT_STAT, 32'h0000_0008, 32'h0000_000B);
    xfer(1'b1, `FTMS_OFS_INT_MASK, 32'h0000_0004);
    xfer(1'b1, `FTMS_OFS_CTRL, 32'h0000_0001);
    wait_irq();
    `CK(lamp, 1'b1)
    rd(`FTMS_OFS_INT_STAT, 32'h0000_0004, 32'h0000_0004);
    skew <= 8'h69;
    repeat (1500) @(posedge hclk);
    rd(`FTMS_OFS_STATUS, 32'h0000_4000, 32'h0000_4000);
    skew <= 8'h70;
    repeat (1500) @(posedge hclk);
    `CK(lamp, 1'b0)
    rd(`FTMS_OFS_STATUS, 32'h0000_0000, 32'h0000_4000);
    rd(`FTMS_OFS_INT_STAT, 32'h0000_0008, 32'h0000_000C);
    `CK(irq, 1'b0)
    xfer(1'b1, `FTMS_OFS_INT_MASK, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    `CK(irq, 1'b0)
    give_verdict();
  end
endmodule // ftms_top_tb_top
